// >>> rtl/smc_pkg.sv
// Purpose : shared types and constants for the sleep mode clock controller
// Assumes : single clock core_clk at 125 MHz, asynchronous active-low reset
// Notes   : mode codes are the values software places on the mode select input
package smc_pkg;

  // sleep mode selection codes
  typedef enum logic [2:0] {
    SMC_MODE_IDLE    = 3'b000,
    SMC_MODE_ADC_NR  = 3'b001,
    SMC_MODE_PWR_DN  = 3'b010,
    SMC_MODE_PWR_SV  = 3'b011,
    SMC_MODE_RSVD_A  = 3'b100,
    SMC_MODE_RSVD_B  = 3'b101,
    SMC_MODE_STANDBY = 3'b110,
    SMC_MODE_EXT_SB  = 3'b111
  } smc_mode_e;

  // controller states
  typedef enum logic [1:0] {
    SMC_ST_ACTIVE = 2'b00,
    SMC_ST_SLEEP  = 2'b01,
    SMC_ST_WAKE   = 2'b10
  } smc_state_e;

  // clock enables for each gated domain
  typedef struct packed {
    logic cpu;    // cpu core clock
    logic io;     // synchronous i/o modules (timers, spi, irq logic, sram)
    logic osc;    // main oscillator
    logic async;  // asynchronous timer clock
    logic adc;    // adc clock
  } smc_gate_s;

  localparam smc_gate_s SMC_GATE_ALL_ON = 5'h1F;
  localparam smc_gate_s SMC_GATE_RST    = 5'h1F;

  // oscillator start-up wait in ns, and derived cycle count at 125 MHz
  localparam int unsigned SMC_CLK_PERIOD_NS  = 8;
  localparam int unsigned SMC_OSC_START_NS   = 64;
  localparam int unsigned SMC_OSC_START_CYC  = (SMC_OSC_START_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
  localparam int unsigned SMC_WAKE_CNT_W     = 8;

endpackage : smc_pkg

// >>> rtl/smc_gate_map.sv
// Purpose : maps a sleep mode code to the set of domains that keep running
// Assumes : purely combinational, result registered by the caller
// Notes   : reserved codes fall back to idle gating
module smc_gate_map (
  input  wire smc_pkg::smc_mode_e mode,  // selected sleep mode
  output smc_pkg::smc_gate_s      gate   // domain enables while asleep
);

  import smc_pkg::*;

  // per-mode domain enables
  always_comb begin
    gate = '0;
    unique case (mode)
      SMC_MODE_IDLE: begin     // see [R2]
        gate.io    = 1'b1;
        gate.osc   = 1'b1;
        gate.async = 1'b1;
        gate.adc   = 1'b1;
      end
      SMC_MODE_ADC_NR: begin   // see [R5]
        gate.osc   = 1'b1;
        gate.async = 1'b1;
        gate.adc   = 1'b1;
      end
      SMC_MODE_PWR_DN: begin   // see [R3]
        gate = '0;
      end
      SMC_MODE_PWR_SV: begin   // see [R4]
        gate.async = 1'b1;
      end
      SMC_MODE_STANDBY: begin  // see [R6]
        gate.osc   = 1'b1;
      end
      SMC_MODE_EXT_SB: begin   // see [R7]
        gate.osc   = 1'b1;
        gate.async = 1'b1;
      end
      default: begin           // reserved codes behave as idle
        gate.io    = 1'b1;
        gate.osc   = 1'b1;
        gate.async = 1'b1;
        gate.adc   = 1'b1;
      end
    endcase
  end

endmodule : smc_gate_map

// >>> rtl/smc_ctrl.sv
// Overview of operation
// [R1] six software-chosen sleep modes, matching gating applied when sleep is entered
// [R2] idle stops cpu clock only; sram, timers, spi, interrupts keep running
// [R3] power-down stops main oscillator and all else until interrupt or reset
// [R4] power-save keeps asynchronous timer running, rest asleep
// [R5] adc noise reduction stops cpu and i/o; async timer and adc run
// [R6] standby keeps oscillator running so wake needs no start-up delay
// [R7] extended standby keeps oscillator and asynchronous timer running
// [R8] on wake, restore all stopped clocks before cpu resumes, return active
//
// Purpose : sleep mode clock gating controller
// Assumes : sleep_req is a one-cycle pulse from the cpu; inputs synchronous to core_clk
// Notes   : cpu_run rises only after every domain enable is already high
//         : the start-up wait is added only after modes that stop the oscillator
module smc_ctrl
#(
  parameter int unsigned OSC_START_CYC = smc_pkg::SMC_OSC_START_CYC
)(
  input  wire logic               core_clk,   // system clock
  input  wire logic               nrst,       // async reset, active low
  input  wire logic               clk_en,     // freezes all state when low
  input  wire logic               sleep_en,   // sleep enable bit from cpu
  input  wire smc_pkg::smc_mode_e sleep_mode, // mode select from cpu
  input  wire logic               sleep_req,  // cpu executes sleep instruction
  input  wire logic               wake_irq,   // enabled interrupt pending
  output smc_pkg::smc_gate_s      gate,       // domain clock enables
  output logic                    cpu_run,    // cpu may execute
  output logic                    asleep      // controller in sleep
);

  import smc_pkg::*;

  // controller registers and the mode map result
  smc_state_e                state_q;
  smc_gate_s                 gate_q;
  smc_gate_s                 map_gate;
  logic [SMC_WAKE_CNT_W-1:0] wcnt_q;
  logic [SMC_WAKE_CNT_W:0]   run_wait_q;     // wake cycles, read by the checks only
  logic                      cpu_run_q;
  logic                      osc_was_off_q;

  // mode code to domain enables
  smc_gate_map u_map (
    .mode (sleep_mode),
    .gate (map_gate)
  );

  // accepted sleep entry and accepted wake event
  wire enter = sleep_req & sleep_en & (state_q == SMC_ST_ACTIVE);
  wire wake  = wake_irq & (state_q == SMC_ST_SLEEP);

  // state sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SMC_ST_ACTIVE;
    end else if (clk_en) begin
      unique case (state_q)
        SMC_ST_ACTIVE: if (enter) state_q <= SMC_ST_SLEEP;             // see [R1]
        SMC_ST_SLEEP:  if (wake) state_q <= SMC_ST_WAKE;               // see [R3]
        SMC_ST_WAKE:   if (wcnt_q == '0) state_q <= SMC_ST_ACTIVE;     // see [R8]
        default:       state_q <= SMC_ST_ACTIVE;
      endcase
    end
  end

  // domain enables: mode gating while asleep, all on from wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gate_q <= SMC_GATE_RST;
    end else if (clk_en) begin
      if (enter) gate_q <= map_gate;                                   // see [R1]
      else if (wake) gate_q <= SMC_GATE_ALL_ON;                        // see [R8]
    end
  end

  // remembers whether the oscillator was stopped, to add start-up wait
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_was_off_q <= 1'b0;
    end else if (clk_en && enter) begin
      osc_was_off_q <= ~map_gate.osc;
    end
  end

  // wake counter: oscillator start-up only when it was stopped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wcnt_q <= '0;
    end else if (clk_en) begin
      if (wake) wcnt_q <= osc_was_off_q ? SMC_WAKE_CNT_W'(OSC_START_CYC) : '0;  // see [R6]
      else if (state_q == SMC_ST_WAKE && wcnt_q != '0) wcnt_q <= wcnt_q - 1'b1;
    end
  end

  // cpu run flag follows the clocks, never ahead of them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_run_q <= 1'b1;
    end else if (clk_en) begin
      if (enter) cpu_run_q <= 1'b0;                                    // see [R2]
      else if (state_q == SMC_ST_WAKE && wcnt_q == '0) cpu_run_q <= 1'b1;  // see [R8]
    end
  end

  // cycles spent in the wake sequence, for the start-up wait check
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_wait_q <= '0;
    end else if (clk_en) begin
      if (wake) begin
        run_wait_q <= '0;
      end else if (state_q == SMC_ST_WAKE) begin
        run_wait_q <= run_wait_q + 1'b1;
      end
    end
  end

  assign gate    = gate_q;
  assign cpu_run = cpu_run_q;

  // sleep indication register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      asleep <= 1'b0;
    end else if (clk_en) begin
      asleep <= (state_q == SMC_ST_SLEEP) ? ~wake : enter;
    end
  end

  // gating applied on sleep entry and held while asleep
  a_enter_gates: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    (enter && clk_en) |=> (gate == $past(map_gate) && !cpu_run))
    else $error("mode gating not applied");
  a_idle_io_on: assert property (@(posedge core_clk) disable iff (!nrst) // see [R2]
    (enter && clk_en && sleep_mode == SMC_MODE_IDLE) |=> gate == 5'h0F)
    else $error("idle gating wrong");
  a_pdn_all_off: assert property (@(posedge core_clk) disable iff (!nrst) // see [R3]
    (enter && clk_en && sleep_mode == SMC_MODE_PWR_DN) |=> gate == 5'h00)
    else $error("power-down gating wrong");
  a_psv_async: assert property (@(posedge core_clk) disable iff (!nrst) // see [R4]
    (enter && clk_en && sleep_mode == SMC_MODE_PWR_SV) |=> gate == 5'h02)
    else $error("power-save gating wrong");
  a_adcnr_gate: assert property (@(posedge core_clk) disable iff (!nrst) // see [R5]
    (enter && clk_en && sleep_mode == SMC_MODE_ADC_NR) |=> gate == 5'h07)
    else $error("adc noise gating wrong");
  a_stby_gate: assert property (@(posedge core_clk) disable iff (!nrst) // see [R6]
    (enter && clk_en && sleep_mode == SMC_MODE_STANDBY) |=> gate == 5'h04)
    else $error("standby gating wrong");
  a_xstby_gate: assert property (@(posedge core_clk) disable iff (!nrst) // see [R7]
    (enter && clk_en && sleep_mode == SMC_MODE_EXT_SB) |=> gate == 5'h06)
    else $error("ext standby gating wrong");
  a_rsvd_idle: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    (enter && clk_en && (sleep_mode == SMC_MODE_RSVD_A || sleep_mode == SMC_MODE_RSVD_B)) |=> gate == 5'h0F)
    else $error("reserved code not gated as idle");
  a_state_legal: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    state_q inside {SMC_ST_ACTIVE, SMC_ST_SLEEP, SMC_ST_WAKE})
    else $error("controller state code illegal");
  a_asleep_state: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    asleep == (state_q == SMC_ST_SLEEP))
    else $error("asleep flag disagrees with state");
  a_sleep_gate_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    (state_q == SMC_ST_SLEEP && !(clk_en && wake_irq)) |=> $stable(gate))
    else $error("gating changed while asleep");
  a_cpu_low_asleep: assert property (@(posedge core_clk) disable iff (!nrst) // see [R2]
    asleep |-> !cpu_run)
    else $error("cpu runs while asleep");

  // refused requests and frozen state
  a_refuse_no_en: assert property (@(posedge core_clk) disable iff (!nrst) // see [R1]
    (clk_en && sleep_req && !sleep_en && state_q == SMC_ST_ACTIVE) |=> (state_q == SMC_ST_ACTIVE && cpu_run && !asleep))
    else $error("sleep entered without enable");
  a_wake_ignored: assert property (@(posedge core_clk) disable iff (!nrst) // see [R3]
    (clk_en && wake_irq && !sleep_req && state_q == SMC_ST_ACTIVE) |=> state_q == SMC_ST_ACTIVE)
    else $error("interrupt moved an active controller");
  a_sleep_holds: assert property (@(posedge core_clk) disable iff (!nrst) // see [R3]
    (state_q == SMC_ST_SLEEP && !wake_irq) |=> state_q == SMC_ST_SLEEP)
    else $error("left sleep without wake");
  a_freeze_all: assert property (@(posedge core_clk) disable iff (!nrst) // see [R3]
    (!clk_en) |=> ($stable(state_q) && $stable(gate) && $stable(wcnt_q)
                   && $stable(cpu_run) && $stable(asleep)))
    else $error("state moved while clock enable low");

  // wake sequencing and the oscillator start-up wait
  a_wake_all_on: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    (clk_en && wake) |=> (gate == SMC_GATE_ALL_ON && !asleep && !cpu_run))
    else $error("wake left a domain stopped");
  a_wcnt_slow: assert property (@(posedge core_clk) disable iff (!nrst) // see [R3]
    (clk_en && wake && osc_was_off_q) |=> wcnt_q == OSC_START_CYC)
    else $error("start-up wait not loaded");
  a_wcnt_fast: assert property (@(posedge core_clk) disable iff (!nrst) // see [R6]
    (clk_en && wake && !osc_was_off_q) |=> wcnt_q == '0)
    else $error("start-up wait loaded with oscillator running");
  a_stby_fast: assert property (@(posedge core_clk) disable iff (!nrst) // see [R6]
    (clk_en && wake && !osc_was_off_q) ##1 clk_en |=> cpu_run)
    else $error("standby wake delayed");
  a_wake_time: assert property (@(posedge core_clk) disable iff (!nrst) // see [R6]
    $rose(cpu_run) |-> run_wait_q == (osc_was_off_q ? OSC_START_CYC + 1 : 1))
    else $error("wake sequence length wrong");
  a_wake_gate_hold: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    (state_q == SMC_ST_WAKE) |-> (gate == SMC_GATE_ALL_ON && !cpu_run))
    else $error("wake sequence gating wrong");
  a_leave_wake: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    (clk_en && state_q == SMC_ST_WAKE && wcnt_q == '0) |=> (state_q == SMC_ST_ACTIVE && cpu_run))
    else $error("wake sequence did not end");
  a_wcnt_rest: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    (state_q != SMC_ST_WAKE) |-> wcnt_q == '0)
    else $error("wake counter busy outside wake");
  a_active_all_on: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    (state_q == SMC_ST_ACTIVE) |-> (gate == SMC_GATE_ALL_ON && cpu_run))
    else $error("active with cpu or domain stopped");
  a_cpu_after_clks: assert property (@(posedge core_clk) disable iff (!nrst) // see [R8]
    cpu_run |-> gate == SMC_GATE_ALL_ON)
    else $error("cpu runs with a domain stopped");

  // coverage of the main scenarios
  c_idle:  cover property (@(posedge core_clk) disable iff (!nrst) enter && sleep_mode == SMC_MODE_IDLE);
  c_pdn:   cover property (@(posedge core_clk) disable iff (!nrst)
    enter && sleep_mode == SMC_MODE_PWR_DN ##[1:50] cpu_run);
  c_stby:  cover property (@(posedge core_clk) disable iff (!nrst) enter && sleep_mode == SMC_MODE_STANDBY);
  c_rsvd:  cover property (@(posedge core_clk) disable iff (!nrst)
    enter && (sleep_mode == SMC_MODE_RSVD_A || sleep_mode == SMC_MODE_RSVD_B));
  c_frz:   cover property (@(posedge core_clk) disable iff (!nrst)
    !clk_en && state_q == SMC_ST_SLEEP);

endmodule : smc_ctrl

// >>> tb/smc_cpu_model.sv
// Purpose : cpu side model that selects a mode, enters sleep and raises wake interrupts
// Assumes : drives just after the rising edge of core_clk
// Notes   : sleep_req is a one-cycle pulse, as the cpu's sleep instruction gives
module smc_cpu_model (
  input  wire logic          core_clk,   // system clock
  output logic               sleep_en,   // sleep enable bit
  output smc_pkg::smc_mode_e sleep_mode, // selected mode
  output logic               sleep_req,  // sleep instruction pulse
  output logic               wake_irq    // pending interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  // quiet cpu at time zero
  initial begin
    sleep_en   = 1'b0;
    sleep_mode = SMC_MODE_IDLE;
    sleep_req  = 1'b0;
    wake_irq   = 1'b0;
  end
  // one sleep instruction with the given enable
  task sleep(input smc_mode_e m, input logic en);
    @(posedge core_clk) #1;
    {sleep_en, sleep_mode, sleep_req} = {en, m, 1'b1};
    @(posedge core_clk) #1;
    sleep_req = 1'b0;
  endtask : sleep
  // one-cycle interrupt
  task wake();
    @(posedge core_clk) #1;
    wake_irq = 1'b1;
    @(posedge core_clk) #1;
    wake_irq = 1'b0;
  endtask : wake
endmodule : smc_cpu_model

// >>> tb/sleep_mode_clock_gating_tb.sv
// Purpose : self-checking bench for the sleep mode clock controller
// Assumes : oscillator wait shortened to OSC cycles
// Notes   : gate bits the modes leave open are masked out
module sleep_mode_clock_gating_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  localparam int unsigned OSC = 4;
  logic        core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic        sleep_en, sleep_req, wake_irq, cpu_run, asleep;
  smc_mode_e   sleep_mode;
  smc_gate_s   gate;
  int          bad_count = 0, n_tests = 0, n;
  logic [31:0] rnd = 32'h9805;
  // free running clock
  initial forever #4 core_clk = ~core_clk;
  smc_cpu_model cpu (.core_clk(core_clk), .sleep_en(sleep_en), .sleep_mode(sleep_mode),
                     .sleep_req(sleep_req), .wake_irq(wake_irq));
  smc_ctrl #(.OSC_START_CYC(OSC)) dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .sleep_en(sleep_en), .sleep_mode(sleep_mode), .sleep_req(sleep_req), .wake_irq(wake_irq),
    .gate(gate), .cpu_run(cpu_run), .asleep(asleep));
  // expected gating {cpu,io,osc,async,adc} and the bits it fixes
  function logic [9:0] exp_gate(input smc_mode_e m);
    case (m)
      SMC_MODE_ADC_NR:  return {5'h1B, 5'h03};
      SMC_MODE_PWR_DN:  return {5'h1F, 5'h00};
      SMC_MODE_PWR_SV:  return {5'h1F, 5'h02};
      SMC_MODE_STANDBY: return {5'h1F, 5'h04};
      SMC_MODE_EXT_SB:  return {5'h1F, 5'h06};
      default:          return {5'h1E, 5'h0E};
    endcase
  endfunction : exp_gate
  // xorshift step for repeatable random draws
  function logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xorshift
  // compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      bad_count++;
    end
  endtask : check
  // verdict and end of run
  task complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // bounded wait for cpu_run, n counts clock edges from the wake edge on, that edge included
  task wait_run();
    n = 1;
    while (cpu_run !== 1'b1 && n < 60) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      complete_run();
    end
  endtask : wait_run
  // enter a mode, check gating, wake and check restore order
  task round(input smc_mode_e m);
    logic [9:0] e;
    e = exp_gate(m);
    cpu.sleep(m, 1'b1);
    check("gate", {27'h0, gate & e[9:5]}, {27'h0, e[4:0]});
    check("asleep", {31'h0, asleep}, 32'h1);
    check("cpu_run", {31'h0, cpu_run}, 32'h0);
    rnd = xorshift(rnd);
    repeat (rnd[1:0]) @(posedge core_clk);
    cpu.wake();
    check("gate wake", {27'h0, gate}, 32'h1F);
    check("cpu_run wake", {31'h0, cpu_run}, 32'h0);
    wait_run();
    if (m != SMC_MODE_ADC_NR) check("wake cycles", n, e[2] ? 2 : 2 + OSC);
    check("asleep wake", {31'h0, asleep}, 32'h0);
    $display("test mode %0d done", m);
  endtask : round
  // main sequence
  initial begin
    #100000 bad_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    check("gate reset", {27'h0, gate}, 32'h1F);
    #1 nrst = 1'b1;
    for (int i = 0; i < 8; i++) round(smc_mode_e'(i));
    cpu.sleep(SMC_MODE_PWR_DN, 1'b0);
    cpu.wake();
    check("refused", {26'h0, asleep, gate}, 32'h1F);
    cpu.sleep(SMC_MODE_PWR_DN, 1'b1);
    clk_en = 1'b0;
    cpu.wake();
    check("frozen", {26'h0, asleep, gate}, 32'h20);
    clk_en = 1'b1;
    cpu.wake();
    wait_run();
    $display("test refuse and freeze done");
    cpu.sleep(SMC_MODE_PWR_DN, 1'b1);
    @(posedge core_clk) #1;
    nrst = 1'b0;
    #1;
    check("reset in sleep", {25'h0, cpu_run, asleep, gate}, 32'h5F);
    @(posedge core_clk) #1;
    nrst = 1'b1;
    @(posedge core_clk) #1;
    check("after reset", {25'h0, cpu_run, asleep, gate}, 32'h5F);
    $display("test reset in sleep done");
    repeat (20) round(smc_mode_e'(rnd[4:2]));
    complete_run();
  end
endmodule : sleep_mode_clock_gating_tb
